// file: ees_i2c_master.sv
`timescale 1ns/1ps
`default_nettype none

module ees_i2c_master (
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_low_out
);
  // Clock stands high between frames
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end

  task automatic start();
    #40 sda_low_out = 1'b0;
    #22 scl_out = 1'b1;
    #40 sda_low_out = 1'b1;
    #40 scl_out = 1'b0;
  endtask

  task automatic stop();
    #40 sda_low_out = 1'b1;
    #22 scl_out = 1'b1;
    #40 sda_low_out = 1'b0;
    #40;
  endtask

  // Data moves late in the low phase so the slave has let go first
  task automatic bit_io(input logic b, output logic r);
    #40 sda_low_out = ~b;
    #22 scl_out = 1'b1;
    #31 r = sda_in;
    #32 scl_out = 1'b0;
  endtask

  task automatic byte_io(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
    output logic nak);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(ack_in, nak);
  endtask
endmodule // ees_i2c_master

`default_nettype wire

// file: ees_pkg.sv
package ees_pkg;

  // Clock and internal write cycle timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int WRITE_TIME_NS = 5000;
  localparam logic [15:0] WRITE_CYCLES = 16'((WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Device select code layout
  localparam int SEL_TYPE_MSB = 7;
  localparam int SEL_TYPE_LSB = 4;
  localparam int SEL_STRAP_MSB = 3;
  localparam int SEL_STRAP_LSB = 1;
  localparam int SEL_DIR_BIT = 0;
  localparam logic [3:0] TYPE_ARRAY = 4'hA;
  localparam logic [3:0] TYPE_ID_PAGE = 4'hB;
  localparam logic DIR_READ = 1'b1;

  // Memory organisation
  localparam int ADDR_W = 12;
  localparam int MEM_DEPTH = 4096;
  localparam int PAGE_OFS_W = 5;
  localparam int ID_PAGE_BYTES = 32;
  localparam int HI_A10_BIT = 2;
  localparam int LOCK_DATA_BIT = 1;

  // Bit slot counts within a byte frame
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] BYTE_DONE = 4'h8;
  localparam logic [3:0] ACK_DONE = 4'h9;
  localparam logic [3:0] TENTH_SLOT = 4'h1;

  typedef enum logic [6:0] {
    ST_STANDBY = 7'h01,
    ST_DEVSEL = 7'h02,
    ST_ADDR_HI = 7'h04,
    ST_ADDR_LO = 7'h08,
    ST_WDATA = 7'h10,
    ST_RDATA = 7'h20,
    ST_WCYCLE = 7'h40
  } ees_state_type;

  typedef struct packed {
    logic write_protect_input;
    logic strap_addr_bit2;
    logic strap_addr_bit1;
    logic strap_addr_bit0;
    logic sda;
    logic scl;
  } ees_pins_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic id_page;
    logic [7:0] wdata;
    logic wvalid;
    logic rd_adv;
    logic wr_start;
    logic lock_req;
  } ees_mem_type;

  typedef struct packed {
    logic tog;
    logic bit_val;
  } ees_link_type;

  typedef struct packed {
    ees_pins_type pin1;
    ees_pins_type pin2;
    logic [1:0] scl_hist;
    logic [1:0] sda_hist;
    logic scl_f;
    logic sda_f;
    logic tog1;
    logic tog2;
    logic tog_seen;
    ees_state_type st;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic ack;
    logic drive_low;
    logic dir_read;
    logic a10_sel;
    logic wr_pending;
    logic lock_pend;
    logic [15:0] wcnt;
    ees_mem_type mem;
  } ees_core_type;

endpackage

// file: ees_slave.sv
`timescale 1ns/1ps
`default_nettype none

module ees_slave
  import ees_pkg::*;
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic scl_clk_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic strap_addr_bit2_in,
  input wire logic strap_addr_bit1_in,
  input wire logic strap_addr_bit0_in,
  input wire logic write_protect_input_in,
  input wire logic id_locked_in,
  input wire logic [7:0] rd_data_in,
  output ees_mem_type mem_out,
  output logic standby_out,
  output logic write_busy_out
);

  ees_core_type q;
  ees_core_type d;
  ees_link_type link_q;
  ees_link_type link_d;
  ees_pins_type pins;
  logic scl_f_next;
  logic sda_f_next;
  logic start_evt;
  logic stop_evt;
  logic scl_fall;
  logic bit_evt;
  logic wr_trig;
  logic [2:0] strap;

  // Link domain: only the bit sample and an event toggle live here
  always_comb begin
    link_d = link_q;
    link_d.bit_val = sda_in;
    link_d.tog = ~link_q.tog;
  end

  // Clock may stop outside frames; nothing here waits for a later edge
  always_ff @(posedge scl_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      link_q <= '0;
    end else begin
      link_q <= link_d;
    end
  end

  always_comb begin
    pins.scl = scl_in;
    pins.sda = sda_in;
    pins.strap_addr_bit2 = strap_addr_bit2_in;
    pins.strap_addr_bit1 = strap_addr_bit1_in;
    pins.strap_addr_bit0 = strap_addr_bit0_in;
    pins.write_protect_input = write_protect_input_in;
  end

  // Glitch filter: a level is taken only after three equal samples
  assign scl_f_next = (q.scl_hist == {2{q.pin2.scl}}) ? q.pin2.scl : q.scl_f;
  assign sda_f_next = (q.sda_hist == {2{q.pin2.sda}}) ? q.pin2.sda : q.sda_f;
  assign start_evt = q.scl_f & scl_f_next & q.sda_f & ~sda_f_next;
  assign stop_evt = q.scl_f & scl_f_next & ~q.sda_f & sda_f_next;
  assign scl_fall = q.scl_f & ~scl_f_next;
  // Bit value is held a full clock period, far longer than the toggle sync
  assign bit_evt = q.tog2 ^ q.tog_seen;
  // Stop right after a data ack: its own rising clock counts as slot one
  assign wr_trig = (q.st == ST_WDATA) && q.wr_pending && (q.bit_cnt == TENTH_SLOT);
  // Floating straps resolve low at the pad pull-down
  assign strap = {q.pin2.strap_addr_bit2, q.pin2.strap_addr_bit1, q.pin2.strap_addr_bit0};

  always_comb begin
    logic [7:0] byte_in;
    logic match;
    logic data_ok;
    byte_in = {q.shreg[6:0], link_q.bit_val};
    match = 1'b0;
    data_ok = 1'b0;
    d = q;
    d.mem.wvalid = 1'b0;
    d.mem.rd_adv = 1'b0;
    d.mem.wr_start = 1'b0;
    d.mem.lock_req = 1'b0;
    d.pin1 = pins;
    d.pin2 = q.pin1;
    d.scl_hist = {q.scl_hist[0], q.pin2.scl};
    d.sda_hist = {q.sda_hist[0], q.pin2.sda};
    d.scl_f = scl_f_next;
    d.sda_f = sda_f_next;
    d.tog1 = link_q.tog;
    d.tog2 = q.tog1;
    d.tog_seen = q.tog2;
    if (q.st == ST_WCYCLE) begin
      // Bus is deaf and the pin stays released until the cycle ends
      d.drive_low = 1'b0;
      d.wcnt = q.wcnt - 16'h0001;
      if (q.wcnt == 16'h0001) begin
        d.st = ST_STANDBY;
      end
    end else if (stop_evt) begin
      d.drive_low = 1'b0;
      d.bit_cnt = 4'h0;
      d.ack = 1'b0;
      d.wr_pending = 1'b0;
      d.lock_pend = 1'b0;
      if (wr_trig) begin
        d.st = ST_WCYCLE;
        d.wcnt = WRITE_CYCLES;
        d.mem.wr_start = 1'b1;
        d.mem.lock_req = q.lock_pend;
      end else begin
        d.st = ST_STANDBY;
      end
    end else if (start_evt) begin
      // Repeated start also lands here, dropping any unfinished write
      d.st = ST_DEVSEL;
      d.bit_cnt = 4'h0;
      d.ack = 1'b0;
      d.drive_low = 1'b0;
      d.wr_pending = 1'b0;
      d.lock_pend = 1'b0;
    end else if (q.st != ST_STANDBY) begin
      if (bit_evt) begin
        d.bit_cnt = q.bit_cnt + 4'h1;
        if (q.bit_cnt < BYTE_DONE) begin
          d.shreg = byte_in;
        end
        if (q.bit_cnt == LAST_DATA_BIT) begin
          case (q.st)
            ST_DEVSEL: begin
              match = ((byte_in[SEL_TYPE_MSB:SEL_TYPE_LSB] == TYPE_ARRAY) ||
                       (byte_in[SEL_TYPE_MSB:SEL_TYPE_LSB] == TYPE_ID_PAGE)) &&
                      (byte_in[SEL_STRAP_MSB:SEL_STRAP_LSB] == strap);
              if (match) begin
                d.ack = 1'b1;
                d.dir_read = (byte_in[SEL_DIR_BIT] == DIR_READ);
                d.mem.id_page = (byte_in[SEL_TYPE_MSB:SEL_TYPE_LSB] == TYPE_ID_PAGE);
              end else begin
                d.st = ST_STANDBY;
                d.ack = 1'b0;
              end
            end
            ST_ADDR_HI: begin
              d.ack = 1'b1;
              d.mem.addr[ADDR_W-1:8] = byte_in[ADDR_W-9:0];
              d.a10_sel = byte_in[HI_A10_BIT];
            end
            ST_ADDR_LO: begin
              d.ack = 1'b1;
              d.mem.addr[7:0] = byte_in;
            end
            ST_WDATA: begin
              // Locked page refuses data the same way protection does
              data_ok = !q.pin2.write_protect_input && !(q.mem.id_page && id_locked_in);
              d.ack = data_ok;
              if (data_ok) begin
                d.mem.wvalid = 1'b1;
                d.mem.wdata = byte_in;
                d.wr_pending = 1'b1;
                if (q.mem.id_page && q.a10_sel && byte_in[LOCK_DATA_BIT]) begin
                  d.lock_pend = 1'b1;
                end
                // Page roll-over: only the offset within the page advances
                d.mem.addr[PAGE_OFS_W-1:0] = q.mem.addr[PAGE_OFS_W-1:0] + 5'h01;
              end
            end
            default: begin
              d.ack = 1'b0;
            end
          endcase
        end
        if ((q.bit_cnt == BYTE_DONE) && (q.st == ST_RDATA)) begin
          d.mem.rd_adv = 1'b1;
          d.mem.addr = q.mem.addr + 12'h001;
          if (link_q.bit_val) begin
            d.st = ST_STANDBY;
          end
        end
      end
      if (scl_fall) begin
        if (q.bit_cnt == BYTE_DONE) begin
          // Pin released for the master's ack when this end transmits
          d.drive_low = (q.st == ST_RDATA) ? 1'b0 : q.ack;
        end else if (q.bit_cnt == ACK_DONE) begin
          d.bit_cnt = 4'h0;
          d.ack = 1'b0;
          d.drive_low = 1'b0;
          case (q.st)
            ST_DEVSEL: begin
              d.st = q.dir_read ? ST_RDATA : ST_ADDR_HI;
            end
            ST_ADDR_HI: begin
              d.st = ST_ADDR_LO;
            end
            ST_ADDR_LO: begin
              d.st = ST_WDATA;
            end
            default: begin
              d.st = q.st;
            end
          endcase
          if ((q.st == ST_RDATA) || ((q.st == ST_DEVSEL) && q.dir_read)) begin
            d.shreg = rd_data_in;
            d.drive_low = ~rd_data_in[7];
          end
        end else if (q.st == ST_RDATA) begin
          d.drive_low = ~q.shreg[7];
        end
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      q <= '0;
      q.st <= ST_STANDBY;
      q.scl_f <= 1'b1;
      q.sda_f <= 1'b1;
      q.scl_hist <= 2'h3;
      q.sda_hist <= 2'h3;
      // Sync stages start at the bus idle level, so no false edge after reset
      q.pin1.scl <= 1'b1;
      q.pin1.sda <= 1'b1;
      q.pin2.scl <= 1'b1;
      q.pin2.sda <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe_out = q.drive_low;
  assign mem_out = q.mem;
  assign standby_out = (q.st == ST_STANDBY);
  assign write_busy_out = (q.st == ST_WCYCLE);

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);

  a_busy_releases_sda: assert property ((q.st == ST_WCYCLE) |-> !sda_oe_out)
    else $error("sda driven during write cycle");

  a_busy_ignores_bus: assert property ((q.st == ST_WCYCLE) && (q.wcnt > 16'h0001) |=> (q.st == ST_WCYCLE))
    else $error("write cycle left early");

  a_stop_starts_write: assert property ((q.st != ST_WCYCLE) && stop_evt && wr_trig
    |=> mem_out.wr_start && (q.st == ST_WCYCLE) && (q.wcnt == WRITE_CYCLES))
    else $error("stop after data ack did not start write cycle");

  a_stop_to_standby: assert property ((q.st != ST_WCYCLE) && stop_evt && !wr_trig
    |=> standby_out && !sda_oe_out)
    else $error("stop did not return to standby");

  a_start_opens_select: assert property ((q.st != ST_WCYCLE) && start_evt && !stop_evt
    |=> (q.st == ST_DEVSEL) && (q.bit_cnt == 4'h0))
    else $error("start not recognised");

  a_strap_mismatch_idle: assert property ((q.st == ST_DEVSEL) && bit_evt && (q.bit_cnt == LAST_DATA_BIT)
    && !start_evt && !stop_evt && (q.shreg[2:0] != strap) |=> standby_out)
    else $error("select mismatch did not deselect");

  a_protect_blocks_write: assert property (mem_out.wvalid |-> !$past(q.pin2.write_protect_input))
    else $error("data accepted while write protected");

  a_protect_data_nack: assert property ((q.st == ST_WDATA) && bit_evt && (q.bit_cnt == LAST_DATA_BIT)
    && !start_evt && !stop_evt && q.pin2.write_protect_input |=> !q.ack ##1 !sda_oe_out)
    else $error("protected data byte acknowledged");

  a_match_drives_ack: assert property ((q.st == ST_DEVSEL) && (q.bit_cnt == BYTE_DONE) && q.ack
    && scl_fall && !start_evt && !stop_evt |=> sda_oe_out)
    else $error("matched select code not acknowledged");

  a_receive_no_drive: assert property (((q.st == ST_ADDR_HI) || (q.st == ST_ADDR_LO) || (q.st == ST_WDATA))
    && (q.bit_cnt < BYTE_DONE) |-> !sda_oe_out)
    else $error("slave drives data while receiving");

  a_read_nack_release: assert property ((q.st == ST_RDATA) && bit_evt && (q.bit_cnt == BYTE_DONE)
    && link_q.bit_val && !start_evt && !stop_evt |=> standby_out ##1 !sda_oe_out)
    else $error("read nack did not end transfer");

  c_select_acked: cover property ((q.st == ST_DEVSEL) && q.ack ##[1:40] (q.st == ST_ADDR_HI));
  c_write_cycle: cover property (mem_out.wr_start);
  c_read_byte: cover property (mem_out.rd_adv ##[1:400] mem_out.rd_adv);
  c_protected_data: cover property ((q.st == ST_WDATA) && q.pin2.write_protect_input && (q.bit_cnt == BYTE_DONE));

endmodule // ees_slave

`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import ees_pkg::*;
  logic clk_in, nrst_in, scl, sda, m_low, sda_out, sda_oe_out, standby_out, write_busy_out;
  logic s2, s1, s0, wp, id_lk, nak, acc, dack, lk;
  int n_wr = 0, n_rd = 0, n_lk = 0, e_wr = 0, e_rd = 0, e_lk = 0;
  logic [7:0] rd_data, rx, sel, hi, lo, d;
  logic [11:0] a;
  ees_mem_type mem_out;
  int fails, num_checks, seed, ty;
  logic [7:0] q_exp[$], q_got[$];

  assign sda = ~((sda_oe_out & ~sda_out) | m_low);

  ees_slave u_dut (.clk_in(clk_in), .nrst_in(nrst_in), .scl_clk_in(scl), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out), .strap_addr_bit2_in(s2), .strap_addr_bit1_in(s1),
    .strap_addr_bit0_in(s0), .write_protect_input_in(wp), .id_locked_in(id_lk), .rd_data_in(rd_data),
    .mem_out(mem_out), .standby_out(standby_out), .write_busy_out(write_busy_out));
  ees_i2c_master u_mst (.sda_in(sda), .scl_out(scl), .sda_low_out(m_low));

  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  // Memory stand-in with a pattern known from the address
  always @(posedge clk_in) begin
    rd_data <= mem_out.addr[7:0] ^ 8'h5A;
    if (mem_out.wvalid) q_got.push_back(mem_out.wdata);
    if (mem_out.wr_start) n_wr <= n_wr + 1;
    if (mem_out.rd_adv) n_rd <= n_rd + 1;
    if (mem_out.lock_req) n_lk <= n_lk + 1;
  end

  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error %0t: %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic chk_val(input logic [11:0] got, input logic [11:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wait_busy(input logic want, input int lim);
    int n;
    n = 0;
    while (write_busy_out !== want && n < lim) begin
      @(posedge clk_in);
      n++;
    end
    if (n >= lim) begin
      fails++;
      $display("Error %0t: write busy wait ran out", $time);
      print_verdict();
    end
  endtask

  // Pins only change in standby, then get time to pass the synchroniser
  task automatic pins(input logic [2:0] st, input logic w, input logic l);
    @(posedge clk_in);
    {s2, s1, s0} <= st;
    wp <= w;
    id_lk <= l;
    repeat (10) @(posedge clk_in);
  endtask

  task automatic head(input logic [7:0] s, input logic e_nak);
    u_mst.start();
    u_mst.byte_io(s, 1'b1, rx, nak);
    chk_bit(nak, e_nak, "select ack");
  endtask

  initial begin
    fails = 0;
    num_checks = 0;
    seed = 9;
    nrst_in = 1'b0;
    {s2, s1, s0} = 3'h0;
    wp = 1'b0;
    id_lk = 1'b0;
    repeat (3) @(posedge clk_in);
    nrst_in <= 1'b1;
    repeat (10) @(posedge clk_in);
    chk_bit(standby_out, 1'b1, "reset standby");
    chk_bit(sda_oe_out | sda_out, 1'b0, "reset release");
    chk_val(mem_out.addr, 12'h000, "reset addr");
    for (int i = 0; i < 14; i++) begin
      pins(3'($random(seed)), 1'($random(seed)), 1'($random(seed)));
      ty = $random(seed) & 3;
      sel = {(ty == 1) ? TYPE_ID_PAGE : (ty == 2) ? 4'h5 : TYPE_ARRAY,
        ($random(seed) & 1) ? {s2, s1, s0} : 3'($random(seed)), 1'b0};
      acc = (ty != 2) && (sel[3:1] == {s2, s1, s0});
      head(sel, !acc);
      dack = 1'b0;
      lk = 1'b0;
      if (acc) begin
        chk_bit(mem_out.id_page, ty == 1, "page select");
        hi = 8'($random(seed)) & 8'h0F;
        lo = 8'($random(seed));
        u_mst.byte_io(hi, 1'b1, rx, nak);
        chk_bit(nak, 1'b0, "high addr ack");
        u_mst.byte_io(lo, 1'b1, rx, nak);
        chk_bit(nak, 1'b0, "low addr ack");
        chk_val(mem_out.addr, {hi[3:0], lo}, "address");
        dack = !wp && !(ty == 1 && id_lk);
        for (int j = 0; j <= (i & 1); j++) begin
          d = 8'($random(seed));
          u_mst.byte_io(d, 1'b1, rx, nak);
          chk_bit(nak, !dack, "data ack");
          if (dack) q_exp.push_back(d);
          if (dack && ty == 1 && hi[2] && d[1]) lk = 1'b1;
        end
      end
      u_mst.stop();
      if (dack) begin
        e_wr++;
        if (lk) e_lk++;
        wait_busy(1'b1, 20);
        head(sel, 1'b1);
        u_mst.stop();
        wait_busy(1'b0, 1100);
      end
      repeat (2) @(posedge clk_in);
      chk_bit(standby_out, 1'b1, "standby after stop");
    end
    chk_val(12'(q_got.size()), 12'(q_exp.size()), "write count");
    while (q_got.size() > 0 && q_exp.size() > 0) chk_val({4'h0, q_got.pop_front()}, {4'h0, q_exp.pop_front()}, "wdata");
    $display("Test write done");
    pins(3'h5, 1'b1, 1'b0);
    for (int k = 0; k < 4; k++) begin
      a = (k == 0) ? 12'hFFF : 12'($random(seed));
      head({TYPE_ARRAY, 3'h5, 1'b0}, 1'b0);
      u_mst.byte_io({4'h0, a[11:8]}, 1'b1, rx, nak);
      u_mst.byte_io(a[7:0], 1'b1, rx, nak);
      head({TYPE_ARRAY, 3'h5, 1'b1}, 1'b0);
      for (int j = 0; j <= (k & 1); j++) begin
        u_mst.byte_io(8'hFF, j == (k & 1), rx, nak);
        chk_val({4'h0, rx}, {4'h0, a[7:0] ^ 8'h5A}, "read data");
        a = a + 12'h001;
        e_rd++;
        chk_val(mem_out.addr, a, "read advance");
      end
      chk_bit(standby_out, 1'b1, "nack standby");
      u_mst.stop();
    end
    $display("Test read done");
    head({TYPE_ARRAY, 3'h5, 1'b0}, 1'b0);
    @(posedge clk_in);
    nrst_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    chk_bit(standby_out, 1'b1, "standby in reset");
    chk_val(mem_out.addr, 12'h000, "addr in reset");
    nrst_in <= 1'b1;
    u_mst.stop();
    repeat (10) @(posedge clk_in);
    head({TYPE_ARRAY, 3'h5, 1'b1}, 1'b0);
    u_mst.byte_io(8'hFF, 1'b1, rx, nak);
    chk_val({4'h0, rx}, 12'h05A, "read after reset");
    e_rd++;
    u_mst.stop();
    $display("Test reset again done");
    repeat (2) @(posedge clk_in);
    chk_val(12'(n_wr), 12'(e_wr), "write starts");
    chk_val(12'(n_rd), 12'(e_rd), "read advances");
    chk_val(12'(n_lk), 12'(e_lk), "lock requests");
    print_verdict();
  end
endmodule // tb_top

`default_nettype wire
